// ==== hw/rif_defines.svh ====
// offsets, field positions, reset values and timing for the remote input block
`ifndef RIF_DEFINES_SVH
`define RIF_DEFINES_SVH

`define RIF_FUNC_BASE 8'h00
`define RIF_FUNC_STEP 8'h04
`define RIF_LEVEL_OFS 8'h14
`define RIF_STATUS_OFS 8'h18

`define RIF_FUNC_LSB 0
`define RIF_FUNC_MSB 4
`define RIF_LEVEL_MSB 3
`define RIF_ST_ACT_LSB 0
`define RIF_ST_FRONT_BIT 4
`define RIF_ST_PEAK_BIT 5
`define RIF_ST_VALLEY_BIT 6
`define RIF_ST_TOGNEXT_BIT 7

`define RIF_LEVEL_RST 4'h0

`define RIF_CLK_HZ 64'd200000000
`define RIF_MSG_PERIOD_S 64'd8
`define RIF_MEM_SHOW_S 64'd20
`define RIF_CLR_HOLD_S 64'd2
`define RIF_MSG_SHOW_MS 64'd1000
`define RIF_TAG_SHOW_MS 64'd1000

`endif

// ==== hw/rif_pkg.sv ====
// types shared by the remote input function block
package rif_pkg;

  typedef enum logic [4:0] {
    RIF_FN_NONE,
    RIF_FN_PEAK_HOLD,
    RIF_FN_DISP_HOLD,
    RIF_FN_PEAK_MEMORY_SETTING,
    RIF_FN_VALLEY_MEMORY_SETTING,
    RIF_FN_PEAK_VALLEY_TOGGLE_SETTING,
    RIF_FN_ALARM_ACK_SETTING,
    RIF_FN_SETUP_GATE_SETTING,
    RIF_FN_BTN_P,
    RIF_FN_BTN_F,
    RIF_FN_BTN_UP,
    RIF_FN_BTN_DOWN,
    RIF_FN_DULL,
    RIF_FN_TOTAL_ZERO_SETTING,
    RIF_FN_GTOTAL_RESET,
    RIF_FN_INHIBIT,
    RIF_FN_TOTAL_PRESET_SETTING
  } rif_func_e;

  typedef enum logic [1:0] {
    RIF_MV_IDLE,
    RIF_MV_TAG,
    RIF_MV_SHOW
  } rif_mv_e;

  typedef struct packed {
    logic peak_hold;
    logic disp_hold;
    logic peak_msg;
    logic hold_msg;
    logic show_peak;
    logic show_valley;
    logic tag_peak;
    logic tag_valley;
    logic reset_msg;
    logic clr_peak;
    logic clr_valley;
    logic dull;
  } rif_disp_s;

  typedef struct packed {
    logic zero;
    logic gzero;
    logic preset;
    logic inhibit;
  } rif_total_s;

  typedef struct packed {
    logic p;
    logic f;
    logic up;
    logic down;
  } rif_btn_s;

endpackage : rif_pkg

// ==== hw/rif_in_chan.sv ====
// one input channel: synchroniser, active level, edge and long-hold detect
`timescale 1ns/10ps
module rif_in_chan #(
  parameter int CW = 35,
  parameter logic [CW-1:0] CLR_CYC = '1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_pin,
  input wire logic i_act_high,
  output logic o_act,
  output logic o_rise,
  output logic o_long
);

  logic [1:0] sync_q;
  // sync resets to 0, not the idle level; mask until it holds a real sample
  logic [1:0] fill_q;
  logic act_q;
  logic rise_q;
  logic long_q;
  logic [CW-1:0] cnt_q;
  wire active_w = fill_q[1] & (sync_q[1] == i_act_high);
  wire cnt_top_w = (cnt_q == CLR_CYC);

  // only sync_q[1] is ever read downstream
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_q <= 2'h0;
      fill_q <= 2'h0;
      act_q <= 1'b0;
      rise_q <= 1'b0;
      long_q <= 1'b0;
      cnt_q <= '0;
    end else if (i_ce) begin
      sync_q <= {sync_q[0], i_pin};
      fill_q <= {fill_q[0], 1'b1};
      act_q <= active_w;
      rise_q <= active_w & ~act_q;
      long_q <= active_w & (cnt_q == CLR_CYC - CW'(1));
      if (!active_w) begin
        cnt_q <= '0;
      end else if (!cnt_top_w) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign o_act = act_q;
  assign o_rise = rise_q;
  assign o_long = long_q;

endmodule : rif_in_chan

// ==== hw/rif_top.sv ====
// remote input function handler with ahb-lite configuration slave
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rif_defines.svh"
module rif_top #(
  parameter int NREM = 4,
  parameter int CW = 35,
  parameter logic [CW-1:0] MSG_PERIOD_CYC =
    CW'(`RIF_MSG_PERIOD_S * `RIF_CLK_HZ),
  parameter logic [CW-1:0] MSG_SHOW_CYC =
    CW'(`RIF_MSG_SHOW_MS * `RIF_CLK_HZ / 64'd1000),
  parameter logic [CW-1:0] MEM_SHOW_CYC =
    CW'(`RIF_MEM_SHOW_S * `RIF_CLK_HZ),
  parameter logic [CW-1:0] CLR_HOLD_CYC =
    CW'(`RIF_CLR_HOLD_S * `RIF_CLK_HZ),
  parameter logic [CW-1:0] TAG_SHOW_CYC =
    CW'(`RIF_TAG_SHOW_MS * `RIF_CLK_HZ / 64'd1000)
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [NREM-1:0] i_remote,
  input wire logic i_front_p,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output rif_pkg::rif_disp_s o_disp,
  output rif_pkg::rif_total_s o_total,
  output rif_pkg::rif_btn_s o_btn,
  output logic o_alarm_ack,
  output logic o_setup_gate
);

  localparam int NCH = NREM + 1;
  localparam int NFN = 17;

  // reset release through two flops; not gated by clock enable
  logic [1:0] rst_sync_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_q[1];

  // configuration state
  rif_pkg::rif_func_e func_q [NCH];
  logic [NREM-1:0] level_q;

  // channels: remote inputs first, front button last
  logic [NCH-1:0] ch_act;
  logic [NCH-1:0] ch_rise;
  logic [NCH-1:0] ch_long;
  wire [NCH-1:0] ch_pin = {i_front_p, i_remote};
  wire [NCH-1:0] ch_high = {1'b1, level_q};

  logic [NFN-1:0] acc_act [NCH+1];
  logic [NFN-1:0] acc_rise [NCH+1];
  logic [NFN-1:0] acc_long [NCH+1];
  assign acc_act[0] = '0;
  assign acc_rise[0] = '0;
  assign acc_long[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      wire [NFN-1:0] hot_w = {{(NFN-1){1'b0}}, 1'b1} << func_q[gi];
      rif_in_chan #(
        .CW(CW),
        .CLR_CYC(CLR_HOLD_CYC)
      ) u_chan (
        .i_clk(i_sys_clk),
        .i_rstn(rst_n),
        .i_ce(i_ce),
        .i_pin(ch_pin[gi]),
        .i_act_high(ch_high[gi]),
        .o_act(ch_act[gi]),
        .o_rise(ch_rise[gi]),
        .o_long(ch_long[gi])
      );
      assign acc_act[gi+1] = acc_act[gi] | (ch_act[gi] ? hot_w : '0);
      assign acc_rise[gi+1] = acc_rise[gi] | (ch_rise[gi] ? hot_w : '0);
      assign acc_long[gi+1] = acc_long[gi] | (ch_long[gi] ? hot_w : '0);
    end
  endgenerate

  // per function, any channel selecting it; none bit is never read
  wire [NFN-1:0] fn_act = acc_act[NCH];
  wire [NFN-1:0] fn_rise = acc_rise[NCH];
  wire [NFN-1:0] fn_long = acc_long[NCH];

  wire act_phold = fn_act[rif_pkg::RIF_FN_PEAK_HOLD];
  wire act_dhold = fn_act[rif_pkg::RIF_FN_DISP_HOLD];
  wire act_pmem = fn_act[rif_pkg::RIF_FN_PEAK_MEMORY_SETTING];
  wire act_vmem = fn_act[rif_pkg::RIF_FN_VALLEY_MEMORY_SETTING];
  wire act_tog = fn_act[rif_pkg::RIF_FN_PEAK_VALLEY_TOGGLE_SETTING];
  wire rise_pmem = fn_rise[rif_pkg::RIF_FN_PEAK_MEMORY_SETTING];
  wire rise_vmem = fn_rise[rif_pkg::RIF_FN_VALLEY_MEMORY_SETTING];
  wire rise_tog = fn_rise[rif_pkg::RIF_FN_PEAK_VALLEY_TOGGLE_SETTING];
  wire long_pmem = fn_long[rif_pkg::RIF_FN_PEAK_MEMORY_SETTING];
  wire long_vmem = fn_long[rif_pkg::RIF_FN_VALLEY_MEMORY_SETTING];
  wire long_tog = fn_long[rif_pkg::RIF_FN_PEAK_VALLEY_TOGGLE_SETTING];
  wire any_mem_act = act_pmem | act_vmem | act_tog;

  // hold message cadence: message at start of each period while held
  logic [CW-1:0] pmsg_cnt_q;
  logic [CW-1:0] dmsg_cnt_q;
  wire pmsg_wrap = (pmsg_cnt_q == MSG_PERIOD_CYC - CW'(1));
  wire dmsg_wrap = (dmsg_cnt_q == MSG_PERIOD_CYC - CW'(1));
  wire pmsg_on = act_phold & (pmsg_cnt_q < MSG_SHOW_CYC);
  wire dmsg_on = act_dhold & (dmsg_cnt_q < MSG_SHOW_CYC);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmsg_cnt_q <= '0;
      dmsg_cnt_q <= '0;
    end else if (i_ce) begin
      pmsg_cnt_q <= (!act_phold || pmsg_wrap) ? '0 : pmsg_cnt_q + CW'(1);
      dmsg_cnt_q <= (!act_dhold || dmsg_wrap) ? '0 : dmsg_cnt_q + CW'(1);
    end
  end

  // memory viewer; peak input wins over valley over toggle on a tie
  rif_pkg::rif_mv_e mv_state_q;
  rif_pkg::rif_mv_e mv_state_d;
  logic mv_valley_q;
  logic mv_valley_d;
  logic tog_next_q;
  logic tog_next_d;
  logic [CW-1:0] mv_tmr_q;
  logic [CW-1:0] mv_tmr_d;
  logic [CW-1:0] rmsg_tmr_q;
  wire mv_tmr_zero = (mv_tmr_q == '0);
  wire any_long = long_pmem | long_vmem | long_tog;
  wire clr_peak_w = long_pmem | (long_tog & ~mv_valley_q);
  wire clr_valley_w = long_vmem | (long_tog & mv_valley_q);

  always_comb begin
    mv_state_d = mv_state_q;
    mv_valley_d = mv_valley_q;
    tog_next_d = tog_next_q;
    mv_tmr_d = mv_tmr_zero ? '0 : mv_tmr_q - CW'(1);
    if (rise_pmem) begin
      mv_state_d = rif_pkg::RIF_MV_SHOW;
      mv_valley_d = 1'b0;
      mv_tmr_d = MEM_SHOW_CYC;
    end else if (rise_vmem) begin
      mv_state_d = rif_pkg::RIF_MV_SHOW;
      mv_valley_d = 1'b1;
      mv_tmr_d = MEM_SHOW_CYC;
    end else if (rise_tog) begin
      mv_state_d = rif_pkg::RIF_MV_TAG;
      mv_valley_d = tog_next_q;
      tog_next_d = ~tog_next_q;
      // timer runs down to zero inclusive, so load one less
      mv_tmr_d = TAG_SHOW_CYC - CW'(1);
    end else begin
      case (mv_state_q)
        rif_pkg::RIF_MV_IDLE: begin
          mv_tmr_d = '0;
        end
        rif_pkg::RIF_MV_TAG: begin
          if (mv_tmr_zero) begin
            mv_state_d = rif_pkg::RIF_MV_SHOW;
            mv_tmr_d = MEM_SHOW_CYC;
          end
        end
        rif_pkg::RIF_MV_SHOW: begin
          // timeout runs from release, so a held input keeps showing
          if (any_mem_act) begin
            mv_tmr_d = MEM_SHOW_CYC;
          end else if (mv_tmr_zero) begin
            mv_state_d = rif_pkg::RIF_MV_IDLE;
          end
        end
        default: begin
          mv_state_d = rif_pkg::RIF_MV_IDLE;
          mv_tmr_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mv_state_q <= rif_pkg::RIF_MV_IDLE;
      mv_valley_q <= 1'b0;
      tog_next_q <= 1'b0;
      mv_tmr_q <= '0;
      rmsg_tmr_q <= '0;
    end else if (i_ce) begin
      mv_state_q <= mv_state_d;
      mv_valley_q <= mv_valley_d;
      tog_next_q <= tog_next_d;
      mv_tmr_q <= mv_tmr_d;
      if (any_long) begin
        rmsg_tmr_q <= MSG_SHOW_CYC;
      end else if (rmsg_tmr_q != '0) begin
        rmsg_tmr_q <= rmsg_tmr_q - CW'(1);
      end
    end
  end

  wire showing = (mv_state_q == rif_pkg::RIF_MV_SHOW);
  wire tagging = (mv_state_q == rif_pkg::RIF_MV_TAG);

  // registered outputs
  rif_pkg::rif_disp_s disp_q;
  rif_pkg::rif_disp_s disp_d;
  rif_pkg::rif_total_s total_q;
  rif_pkg::rif_total_s total_d;
  rif_pkg::rif_btn_s btn_q;
  rif_pkg::rif_btn_s btn_d;
  logic ack_q;
  logic gate_q;

  assign disp_d.peak_hold = act_phold;
  assign disp_d.disp_hold = act_dhold;
  assign disp_d.peak_msg = pmsg_on;
  assign disp_d.hold_msg = dmsg_on;
  assign disp_d.show_peak = showing & ~mv_valley_q;
  assign disp_d.show_valley = showing & mv_valley_q;
  assign disp_d.tag_peak = tagging & ~mv_valley_q;
  assign disp_d.tag_valley = tagging & mv_valley_q;
  assign disp_d.reset_msg = (rmsg_tmr_q != '0);
  assign disp_d.clr_peak = clr_peak_w;
  assign disp_d.clr_valley = clr_valley_w;
  assign disp_d.dull = fn_act[rif_pkg::RIF_FN_DULL];
  assign total_d.zero = fn_rise[rif_pkg::RIF_FN_TOTAL_ZERO_SETTING];
  assign total_d.gzero = fn_rise[rif_pkg::RIF_FN_GTOTAL_RESET];
  assign total_d.preset =
    fn_rise[rif_pkg::RIF_FN_TOTAL_PRESET_SETTING];
  assign total_d.inhibit = fn_act[rif_pkg::RIF_FN_INHIBIT];
  assign btn_d.p = fn_act[rif_pkg::RIF_FN_BTN_P];
  assign btn_d.f = fn_act[rif_pkg::RIF_FN_BTN_F];
  assign btn_d.up = fn_act[rif_pkg::RIF_FN_BTN_UP];
  assign btn_d.down = fn_act[rif_pkg::RIF_FN_BTN_DOWN];
  // one pulse reaches every alarm that wants acknowledgement
  wire ack_d = fn_rise[rif_pkg::RIF_FN_ALARM_ACK_SETTING];
  wire gate_d = fn_act[rif_pkg::RIF_FN_SETUP_GATE_SETTING];

  // clear pulses sit high in reset so memories start empty after power up
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_q <= '0;
      disp_q.clr_peak <= 1'b1;
      disp_q.clr_valley <= 1'b1;
      total_q <= '0;
      btn_q <= '0;
      ack_q <= 1'b0;
      gate_q <= 1'b0;
    end else if (i_ce) begin
      disp_q <= disp_d;
      total_q <= total_d;
      btn_q <= btn_d;
      ack_q <= ack_d;
      gate_q <= gate_d;
    end
  end

  assign o_disp = disp_q;
  assign o_total = total_q;
  assign o_btn = btn_q;
  assign o_alarm_ack = ack_q;
  assign o_setup_gate = gate_q;

  // ahb-lite slave, zero wait states, always okay
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  wire take = i_hsel & i_hready & i_htrans[1];
  wire [7:0] raddr = i_haddr[7:0];
  wire [5:0] ridx = raddr[7:2];
  wire [5:0] widx = waddr_q[7:2];
  wire [5:0] func_base_idx = 6'(`RIF_FUNC_BASE >> 2);
  wire [5:0] level_idx = 6'(`RIF_LEVEL_OFS >> 2);
  wire [5:0] status_idx = 6'(`RIF_STATUS_OFS >> 2);
  wire r_func = (ridx >= func_base_idx) &&
    (ridx < func_base_idx + 6'(NCH));
  wire [5:0] r_fsel = ridx - func_base_idx;
  wire [5:0] w_fsel = widx - func_base_idx;
  wire w_func = wr_q && (widx >= func_base_idx) &&
    (widx < func_base_idx + 6'(NCH));
  wire w_level = wr_q && (widx == level_idx);

  wire [31:0] status_w = {24'h000000, tog_next_q, disp_q.show_valley,
    disp_q.show_peak, ch_act[NREM], ch_act[NREM-1:0]};
  wire [31:0] rd_mux =
    r_func ? {27'h0000000, func_q[r_fsel[2:0]]} :
    (ridx == level_idx) ? {{(32-NREM){1'b0}}, level_q} :
    (ridx == status_idx) ? status_w :
    32'h00000000;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b0;
      level_q <= NREM'(`RIF_LEVEL_RST);
    end else if (i_ce) begin
      hready_q <= 1'b1;
      wr_q <= take & i_hwrite;
      waddr_q <= raddr;
      hrdata_q <= (take & ~i_hwrite) ? rd_mux : 32'h00000000;
      if (w_level) begin
        level_q <= i_hwdata[NREM-1:0];
      end
    end
  end

  generate
    for (gi = 0; gi < NCH; gi++) begin : g_func
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          func_q[gi] <= rif_pkg::RIF_FN_NONE;
        end else if (i_ce && w_func && (w_fsel == 6'(gi))) begin
          func_q[gi] <= rif_pkg::rif_func_e'(
            i_hwdata[`RIF_FUNC_MSB:`RIF_FUNC_LSB]);
        end
      end
    end
  endgenerate

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;

endmodule : rif_top

// ==== testbench/rif_chk.sv ====
// port assertions for the remote input function block
`timescale 1ns/10ps
module rif_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire rif_pkg::rif_disp_s o_disp,
  input wire rif_pkg::rif_total_s o_total,
  input wire logic o_alarm_ack
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic rd_q;
  logic rd_d;
  // read data may only stand in the cycle after a read address phase
  assign rd_d = i_hsel & i_hready & i_htrans[1] & !i_hwrite & i_ce;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) rd_q <= 1'b0;
    else rd_q <= rd_d;
  end
  sequence s_clr;
    $rose(o_disp.clr_peak || o_disp.clr_valley);
  endsequence
  sequence s_rmsg;
    ##[0:2] o_disp.reset_msg;
  endsequence
  property p_clr_msg;
    s_clr |-> s_rmsg;
  endproperty
  a_clr_msg: assert property (p_clr_msg)
    else $error("memory clear without reset message");
  property p_ack;
    o_alarm_ack |=> !o_alarm_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge pulse too long");
  property p_zero;
    o_total.zero |=> !o_total.zero;
  endproperty
  a_zero: assert property (p_zero)
    else $error("total zero pulse too long");
  property p_gzero;
    o_total.gzero |=> !o_total.gzero;
  endproperty
  a_gzero: assert property (p_gzero)
    else $error("grand total pulse too long");
  property p_preset;
    o_total.preset |=> !o_total.preset;
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset pulse too long");
  property p_pmsg;
    o_disp.peak_msg |-> o_disp.peak_hold || $past(o_disp.peak_hold);
  endproperty
  a_pmsg: assert property (p_pmsg)
    else $error("peak message without peak hold");
  property p_hmsg;
    o_disp.hold_msg |-> o_disp.disp_hold || $past(o_disp.disp_hold);
  endproperty
  a_hmsg: assert property (p_hmsg)
    else $error("hold message without display hold");
  property p_tag;
    !(o_disp.tag_peak && o_disp.tag_valley);
  endproperty
  a_tag: assert property (p_tag)
    else $error("both type tags shown");
  property p_pmsg_start;
    $rose(o_disp.peak_hold) |-> o_disp.peak_msg;
  endproperty
  a_pmsg_start: assert property (p_pmsg_start)
    else $error("peak hold began without message");
  property p_hmsg_start;
    $rose(o_disp.disp_hold) |-> o_disp.hold_msg;
  endproperty
  a_hmsg_start: assert property (p_hmsg_start)
    else $error("display hold began without message");
  sequence s_tag_end;
    $fell(o_disp.tag_peak || o_disp.tag_valley);
  endsequence
  property p_tag_show;
    s_tag_end |-> o_disp.show_peak || o_disp.show_valley;
  endproperty
  a_tag_show: assert property (p_tag_show)
    else $error("type tag not followed by memory display");
  property p_rdy;
    o_hreadyout |=> o_hreadyout && !o_hresp;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("bus wait or error response");
  property p_rdat;
    !rd_q |-> o_hrdata == 32'h0;
  endproperty
  a_rdat: assert property (p_rdat)
    else $error("read data outside data phase");
endmodule : rif_chk

bind rif_top rif_chk rif_chk_inst (.i_sys_clk, .i_rstn, .i_ce, .i_hsel,
  .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
  .o_disp, .o_total, .o_alarm_ack);

// ==== testbench/rif_contacts.sv ====
// contact closures on the four remote input terminals
`timescale 1ns/10ps
module rif_contacts (
  input wire logic [3:0] i_closed,
  input wire logic [3:0] i_hi_act,
  output logic [3:0] o_pin
);
  // an open terminal rests at its pull level, the inactive one
  assign o_pin = ~(i_closed ^ i_hi_act);
endmodule : rif_contacts

// ==== testbench/rif_top_tb_top.sv ====
// self-checking bench for the remote input function block
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  n_fail++; $display("Error %s exp %0h got %0h", n, e, g); end end
module rif_top_tb_top;
  localparam int MEMC = 100;
  localparam int CLRC = 20;
  localparam int PER = 64;
  localparam int SHOW = 8;
  localparam int TAG = 10;
  // function codes, the four pulse functions first and then the level ones, and the output bit each one drives
  localparam int FN [13] = '{6, 13, 14, 16, 1, 2, 7, 8, 9, 10, 11, 12, 15};
  localparam int BT [13] = '{1, 9, 8, 7, 21, 20, 0, 5, 4, 3, 2, 10, 6};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic front = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [3:0] closed = 4'h0;
  logic [3:0] hi_act = 4'h0;
  logic [3:0] pin;
  logic hready;
  logic hresp;
  logic ack;
  logic gate;
  rif_pkg::rif_disp_s disp;
  rif_pkg::rif_total_s tot;
  rif_pkg::rif_btn_s btn;
  wire logic [21:0] outs = {disp, tot, btn, ack, gate};
  int n_fail = 0;
  int compares = 0;
  int k;
  int j;
  int c;
  always #2.5 clk = ~clk;
  rif_contacts rif_contacts_inst (.i_closed(closed), .i_hi_act(hi_act),
    .o_pin(pin));
  rif_top #(.MSG_PERIOD_CYC(35'(PER)), .MSG_SHOW_CYC(35'(SHOW)),
    .MEM_SHOW_CYC(35'(MEMC)), .CLR_HOLD_CYC(35'(CLRC)),
    .TAG_SHOW_CYC(35'(TAG))) rif_top_inst (.i_sys_clk(clk),
    .i_rstn(rstn), .i_ce(ce), .i_remote(pin), .i_front_p(front),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_disp(disp), .o_total(tot), .o_btn(btn), .o_alarm_ack(ack),
    .o_setup_gate(gate));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic xfer(input logic w, input logic [31:0] a, v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask : xfer
  task automatic cnt(input int b, n);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += (outs[b] === 1'b1);
    end
  endtask : cnt
  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task t_regs;
    for (k = 0; k < 7; k++) begin
      xfer(1'b0, 4 * k, 32'h0);
      `CHK("reset reg", 32'h0, d)
    end
    xfer(1'b1, 32'h8, 32'hFFFFFFFF);
    xfer(1'b0, 32'h8, 32'h0);
    `CHK("func2", 32'h1F, d)
    xfer(1'b1, 32'h40, 32'h5);
    xfer(1'b0, 32'h40, 32'h0);
    `CHK("unmapped", 32'h0, d)
  endtask : t_regs
  task t_none;
    // code 31 on input 2 must act as no function
    closed <= 4'hF;
    front <= 1'b1;
    cyc(10);
    `CHK("idle outs", 22'h0, outs)
    xfer(1'b0, 32'h18, 32'h0);
    `CHK("status", 32'h1F, d & 32'hFF)
    closed <= 4'h0;
    front <= 1'b0;
    xfer(1'b1, 32'h8, 32'h0);
    cyc(6);
  endtask : t_none
  task t_func;
    xfer(1'b1, 32'h14, 32'h8);
    hi_act <= 4'h8;
    for (k = 0; k < 13; k++) begin
      xfer(1'b1, 4 * (k % 4), FN[k]);
      closed[k % 4] <= 1'b1;
      if (k < 4) begin
        cnt(BT[k], 12);
        `CHK("pulse", 1, c)
      end else begin
        cyc(6);
        `CHK("level on", 1'b1, outs[BT[k]])
      end
      closed[k % 4] <= 1'b0;
      cyc(6);
      `CHK("level off", 1'b0, outs[BT[k]])
      xfer(1'b1, 4 * (k % 4), 32'h0);
    end
    xfer(1'b1, 32'h10, 32'h6);
    front <= 1'b1;
    cnt(1, 12);
    `CHK("front ack", 1, c)
    front <= 1'b0;
    xfer(1'b1, 32'h10, 32'h0);
  endtask : t_func
  task t_msg;
    for (j = 0; j < 2; j++) begin
      xfer(1'b1, 32'h0, 1 + j);
      closed[0] <= 1'b1;
      k = 0;
      while (outs[19 - j] !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      cnt(19 - j, PER);
      `CHK("message", SHOW, c)
      closed[0] <= 1'b0;
      xfer(1'b1, 32'h0, 32'h0);
      cyc(12);
    end
  endtask : t_msg
  task t_mem;
    for (j = 0; j < 2; j++) begin
      xfer(1'b1, 32'h0, 3 + j);
      closed[0] <= 1'b1;
      cyc(6);
      closed[0] <= 1'b0;
      cyc(50);
      `CHK("shown", 1'b1, outs[17 - j])
      cyc(60);
      `CHK("timed out", 1'b0, outs[17 - j])
      closed[0] <= 1'b1;
      cnt(12 - j, CLRC + 10);
      `CHK("clear", 1, c)
      closed[0] <= 1'b0;
      cyc(MEMC + 15);
      xfer(1'b1, 32'h0, 32'h0);
    end
  endtask : t_mem
  task t_tog;
    xfer(1'b1, 32'h0, 32'h5);
    closed[0] <= 1'b1;
    cnt(15, 20);
    `CHK("peak tag", TAG, c)
    `CHK("peak shown", 1'b1, outs[17])
    xfer(1'b0, 32'h18, 32'h0);
    `CHK("next valley", 32'h1, (d >> 7) & 32'h1)
    closed[0] <= 1'b0;
    cyc(6);
    closed[0] <= 1'b1;
    cnt(14, 20);
    `CHK("valley tag", TAG, c)
    closed[0] <= 1'b0;
    cyc(MEMC + 15);
    xfer(1'b1, 32'h0, 32'h0);
  endtask : t_tog
  task t_ce;
    // enable low freezes the input path, so a press waits for it
    xfer(1'b1, 32'h0, 32'h6);
    ce <= 1'b0;
    closed[0] <= 1'b1;
    cnt(1, 12);
    `CHK("frozen ack", 0, c)
    ce <= 1'b1;
    cnt(1, 12);
    `CHK("thawed ack", 1, c)
    closed[0] <= 1'b0;
    cyc(6);
    xfer(1'b1, 32'h0, 32'h0);
  endtask : t_ce
  task t_rst;
    // power loss mid-run: memories clear, toggle restarts at peak
    xfer(1'b1, 32'h0, 32'h5);
    closed[0] <= 1'b1;
    cyc(6);
    closed[0] <= 1'b0;
    hi_act <= 4'h0;
    rstn <= 1'b0;
    cyc(2);
    `CHK("reset clear", 2'h3, outs[12:11])
    rstn <= 1'b1;
    do cyc(1); while (hready !== 1'b1);
    `CHK("after reset", 22'h0, outs)
    xfer(1'b0, 32'h18, 32'h0);
    `CHK("status reset", 32'h0, d)
    xfer(1'b0, 32'h0, 32'h0);
    `CHK("func reset", 32'h0, d)
  endtask : t_rst
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end
  initial begin
    cyc(6);
    rstn <= 1'b1;
    do cyc(1); while (hready !== 1'b1);
    t_regs();
    t_none();
    t_func();
    t_msg();
    t_mem();
    t_tog();
    t_ce();
    t_rst();
    print_verdict();
  end
endmodule : rif_top_tb_top
